// [rtl/pt8_timer.sv]
// 8-bit period timer with prescaler, period match, postscaler and flag,
// reached over an AHB-Lite slave. Assumes hclk is the oscillator clock.
//
// Summary of operation
// - Count on oscillator/4 through prescaler: 00 by 1, 01 by 4, 1x by 16.
// - Count up from 00h; on equal to period, next increment returns to 00h.
// - Period register is read/write and resets to FFh.
// - Match pulses pass a 1..16 postscaler; each output sets flag bit 1.
// - Control bits 6..3 select postscale: 0000 by 1 up to 1111 by 16.
// - Control bit 2 runs the timer; zero halts counting.
// - Count register is read/write and clears on every reset.
// - Writes to count or control, and reset, clear pre- and postscaler.
// - Writing control leaves the count unchanged.
// - Match pulse ahead of postscaler goes out to the serial port.
// - Only control bits 6..0 exist; bit 7 reads zero; all reset to zero.
`timescale 1ns/1ps

module pt8_timer
   import pt8_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   output logic             sync_serial_port_clk
);
   import pt8_pkg::*;

   // ==========================================================
   // Bus request capture
   pt8_req_s    req_q, req_d;
   logic [31:0] rdata_q, rdata_d;

   logic        addr_ok;
   logic        wr_count, wr_control, wr_period, wr_flags, wr_enables;
   logic [7:0]  wbyte;

   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wbyte   = hwdata[7:0];

   always_comb begin
      req_d.wr  = addr_ok && hwrite;
      req_d.rd  = addr_ok && !hwrite;
      req_d.idx = haddr[ADDR_LSB +: ADDR_W];
   end

   always_comb begin
      wr_count   = req_q.wr && (req_q.idx == ADDR_W'(IDX_COUNT));
      wr_control = req_q.wr && (req_q.idx == ADDR_W'(IDX_CONTROL));
      wr_period  = req_q.wr && (req_q.idx == ADDR_W'(IDX_PERIOD));
      wr_flags   = req_q.wr && (req_q.idx == ADDR_W'(IDX_FLAGS));
      wr_enables = req_q.wr && (req_q.idx == ADDR_W'(IDX_ENABLES));
   end

   // ==========================================================
   // Registers
   logic [7:0] count_q, count_d;
   logic [7:0] control_q, control_d;
   logic [7:0] period_q, period_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] enables_q, enables_d;
   logic       match_q, match_d;
   logic       irq_q, irq_d;
   logic       ready_q;
   logic       resp_q;

   logic       instr_tick;
   logic [3:0] pre_last;
   logic       pre_step;
   logic       pre_wrap;
   logic       count_tick;
   logic       match_evt;
   logic       post_evt;
   logic       scaler_clr;
   logic [3:0] post_sel;

   assign post_sel   = control_q[POST_LSB +: 4];
   assign scaler_clr = wr_count || wr_control;

   // ==========================================================
   // Prescaler and postscaler chain

   always_comb begin
      case (control_q[1:0])
         2'b00:   pre_last = PRE_LAST_1;
         2'b01:   pre_last = PRE_LAST_4;
         default: pre_last = PRE_LAST_16;
      endcase
   end

   // Divider free-runs, halted or not, so the oscillator/4 phase
   // stays steady; it is not one of the scalers a write clears.
   pt8_wrap_cnt #(
      .W      (2)
   ) u_instr_div (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clr    (1'b0),
      .step   (1'b1),
      .last   (INSTR_DIV_LAST),
      .wrap   (instr_tick)
   );

   assign pre_step = control_q[ON_BIT] && instr_tick;

   pt8_wrap_cnt #(
      .W      (4)
   ) u_prescale (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clr    (scaler_clr),
      .step   (pre_step),
      .last   (pre_last),
      .wrap   (pre_wrap)
   );

   // A write that clears the scalers also swallows that cycle's tick
   assign count_tick = pre_wrap && !scaler_clr;
   assign match_evt  = count_tick && (count_q == period_q);

   pt8_wrap_cnt #(
      .W      (4)
   ) u_postscale (
      .clk    (hclk),
      .rst_n  (hresetn),
      .clr    (scaler_clr),
      .step   (match_evt),
      .last   (post_sel),
      .wrap   (post_evt)
   );

   // ==========================================================
   // Count register; only its own write loads it
   always_comb begin
      count_d = count_q;
      if (wr_count) begin
         count_d = wbyte;
      end else if (match_evt) begin
         count_d = 8'h00;
      end else if (count_tick) begin
         count_d = count_q + 8'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= COUNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // Software settings: control, period, enables
   always_comb begin
      control_d = control_q;
      period_d  = period_q;
      enables_d = enables_q;
      if (wr_control) begin
         control_d = wbyte & CTRL_MASK;
      end
      if (wr_period) begin
         period_d = wbyte;
      end
      if (wr_enables) begin
         enables_d = wbyte & FLAG_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         control_q <= CONTROL_RST;
         period_q  <= PERIOD_RST;
         enables_q <= ENABLES_RST;
      end else begin
         control_q <= control_d;
         period_q  <= period_d;
         enables_q <= enables_d;
      end
   end

   // ==========================================================
   // Event flag; write one to clear, a postscaler event wins
   always_comb begin
      flags_d = flags_q;
      if (wr_flags) begin
         flags_d = flags_q & ~(wbyte & FLAG_MASK);
      end
      if (post_evt) begin
         flags_d[FLAG_BIT] = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // ==========================================================
   // Interrupt level; registered from the next-state flag, so it changes with the flag
   always_comb begin
      irq_d = |(flags_d & enables_d);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   // ==========================================================
   // Match pulse to the serial port, taken ahead of the postscaler
   always_comb begin
      match_d = match_evt;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         match_q <= 1'b0;
      end else begin
         match_q <= match_d;
      end
   end

   // ==========================================================
   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (req_d.rd) begin
         case (req_d.idx)
            ADDR_W'(IDX_FLAGS):   rdata_d = {24'h000000, flags_d};
            ADDR_W'(IDX_COUNT):   rdata_d = {24'h000000, count_d};
            ADDR_W'(IDX_CONTROL): rdata_d = {24'h000000, control_d};
            ADDR_W'(IDX_ENABLES): rdata_d = {24'h000000, enables_d};
            ADDR_W'(IDX_PERIOD):  rdata_d = {24'h000000, period_d};
            default:              rdata_d = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Bus state; the slave never stalls and never errors
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q   <= '0;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end else begin
         req_q   <= req_d;
         rdata_q <= rdata_d;
         ready_q <= 1'b1;
         resp_q  <= 1'b0;
      end
   end

   assign hrdata               = rdata_q;
   assign hreadyout            = ready_q;
   assign hresp                = resp_q;
   assign irq                  = irq_q;
   assign sync_serial_port_clk = match_q;

endmodule // pt8_timer

// ==========================================================
// Wrapping counter shared by the divider and both scalers
module pt8_wrap_cnt #(
   parameter int W = 4
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         step,
   input  wire logic [W-1:0] last,
   output logic              wrap
);
   import pt8_pkg::*;

   logic [W-1:0] cnt_q, cnt_d;

   // Combinational so the next stage sees the wrap in the same cycle
   assign wrap = step && (cnt_q == last);

   always_comb begin
      cnt_d = cnt_q;
      if (clr) begin
         cnt_d = '0;
      end else if (step) begin
         cnt_d = wrap ? '0 : cnt_q + W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule // pt8_wrap_cnt

// [rtl/pt8_pkg.sv]
// Package for the 8-bit period timer: register map, field layout, resets.
// Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
package pt8_pkg;

   // ==========================================================
   // Register indices as printed; byte address is four times
   localparam logic [7:0]  IDX_FLAGS   = 8'h0C;
   localparam logic [7:0]  IDX_COUNT   = 8'h11;
   localparam logic [7:0]  IDX_CONTROL = 8'h12;
   localparam logic [7:0]  IDX_ENABLES = 8'h8C;
   localparam logic [7:0]  IDX_PERIOD  = 8'h92;
   localparam int          ADDR_LSB    = 2;
   localparam int          ADDR_W      = 10;

   // ==========================================================
   // Field positions
   localparam int          FLAG_BIT    = 1;
   localparam int          ON_BIT      = 2;
   localparam int          POST_LSB    = 3;
   localparam logic [7:0]  CTRL_MASK   = 8'h7F;
   localparam logic [7:0]  FLAG_MASK   = 8'h02;

   // ==========================================================
   // Reset values
   localparam logic [7:0]  COUNT_RST   = 8'h00;
   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [7:0]  PERIOD_RST  = 8'hFF;
   localparam logic [7:0]  FLAGS_RST   = 8'h00;
   localparam logic [7:0]  ENABLES_RST = 8'h00;

   // ==========================================================
   // Timing: instruction clock is the bus clock divided by four
   localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
   localparam logic [3:0]  PRE_LAST_1     = 4'h0;
   localparam logic [3:0]  PRE_LAST_4     = 4'h3;
   localparam logic [3:0]  PRE_LAST_16    = 4'hF;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] idx;
   } pt8_req_s;

endpackage : pt8_pkg

// [bench/pt8_timer_sva.sv]
// Checker for the period timer: bus answers, read data, match pulse, irq.
// Sees only the top module's ports; bound in below its endmodule.
`timescale 1ns/1ps
module pt8_timer_sva
   import pt8_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        irq,
   input wire logic        sync_serial_port_clk
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
   wire logic rd   = take && !hwrite;
   wire logic wr   = take && hwrite;
   // ==========================================================
   // Bus answer and read data
   okay_resp_a: assert property (!hresp && hreadyout)
      else $error("slave answer not zero-wait OKAY");
   idle_rdata_a: assert property (!rd |=> hrdata == 32'h0)
      else $error("read data not zero outside a read");
   upper_zero_a: assert property (rd |=> hrdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   ctrl_bit7_a: assert property (rd && haddr == 32'h48 |=> !hrdata[7])
      else $error("control bit 7 reads as one");
   flag_bits_a: assert property (rd && (haddr == 32'h30 ||
      haddr == 32'h230) |=> (hrdata[7:0] & 8'hFD) == 8'h0)
      else $error("unimplemented flag or enable bit reads one");
   // ==========================================================
   // Match pulse and interrupt
   match_gap_a: assert property (sync_serial_port_clk
      |=> !sync_serial_port_clk [*3]) else $error("match pulses too close");
   halt_a: assert property (wr && haddr == 32'h48 ##1 !hwdata[ON_BIT]
      |=> ##1 !sync_serial_port_clk [*3]) else $error("match while halted");
   irq_mask_a: assert property (wr && haddr == 32'h230
      ##1 !hwdata[FLAG_BIT] |-> ##[1:2] !irq) else $error("irq not masked");
endmodule // pt8_timer_sva

bind pt8_timer pt8_timer_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .irq,
   .sync_serial_port_clk);

// [bench/pt8_timer_tb.sv]
// Self-checking bench for the period timer, driven as an AHB-Lite master.
// Assumes the zero-wait slave; hready is looped back from hreadyout.
`timescale 1ns/1ps
module pt8_timer_tb;
   import pt8_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic        sync_serial_port_clk;
   logic [31:0] haddr, hwdata, hrdata, seed, rv, v;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  p;
   int          n_errors, checked, c;
   logic [31:0] addrs [6] = '{32'h30, 32'h44, 32'h48, 32'h230, 32'h248, 32'h3FC};
   logic [31:0] rst_v [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFF, 32'h0};
   pt8_timer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq,
      .sync_serial_port_clk);
   initial begin
      hclk = 1'h0;
      forever #5 hclk = ~hclk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int ticks(logic [1:0] pre, logic [7:0] per);
      return 4 * (pre == 2'h0 ? 1 : pre == 2'h1 ? 4 : 16) * (per + 1);
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded wait for a high level; a timeout ends the run
   task automatic wait_on(ref logic s, output int n);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (s !== 1'h1 && n < 5000);
      if (n >= 5000) begin
         n_errors++;
         print_verdict();
      end
   endtask
   task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
      int k;
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= a;
      wait_on(hreadyout, k);
      htrans <= 2'h0;
      hwdata <= d;
      wait_on(hreadyout, k);
      rv = hrdata;
   endtask
   task automatic print_verdict();
      $display("Counts: %0d checked, %0d mismatched", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      n_errors = 0;
      checked = 0;
      seed = 32'h615BD34F;
      repeat (16) @(posedge hclk);
      hresetn <= 1'h1;
      foreach (addrs[i]) begin
         xfer(1'h0, addrs[i], 32'h0);
         chk("reset value", rst_v[i], rv);
      end
      v = rnd() & 32'hFF;
      xfer(1'h1, 32'h44, v);
      xfer(1'h1, 32'h48, 32'hFB);
      xfer(1'h0, 32'h48, 32'h0);
      chk("control", 32'h7B, rv);
      xfer(1'h0, 32'h44, 32'h0);
      chk("count", v, rv);
      xfer(1'h1, 32'h248, v ^ 32'h5A);
      xfer(1'h0, 32'h248, 32'h0);
      chk("period", v ^ 32'h5A, rv);
      $display("register test done");
      for (int m = 0; m < 4; m++) begin
         p = 8'(rnd() & 32'h7);
         xfer(1'h1, 32'h248, {24'h0, p});
         xfer(1'h1, 32'h44, 32'h0);
         xfer(1'h1, 32'h48, 32'h4 | m);
         wait_on(sync_serial_port_clk, c);
         wait_on(sync_serial_port_clk, c);
         chk("match spacing", ticks(2'(m), p), c);
      end
      $display("prescale test done");
      xfer(1'h1, 32'h248, 32'h0);
      xfer(1'h1, 32'h230, 32'h2);
      for (int s = 0; s < 16; s++) begin
         xfer(1'h1, 32'h48, 32'h0);
         xfer(1'h1, 32'h30, 32'h2);
         xfer(1'h1, 32'h48, (s << 3) | 32'h4);
         c = 0;
         for (int k = 0; k < 300 && irq !== 1'h1; k++) begin
            @(posedge hclk);
            if (sync_serial_port_clk === 1'h1) c++;
         end
         if (irq !== 1'h1) begin
            n_errors++;
            print_verdict();
         end
         chk("postscale", s + 1, c);
      end
      $display("postscale test done");
      xfer(1'h1, 32'h48, 32'h0);
      xfer(1'h1, 32'h230, 32'h0);
      repeat (3) @(posedge hclk);
      chk("masked irq", 32'h0, {31'h0, irq});
      xfer(1'h0, 32'h30, 32'h0);
      chk("sticky flag", 32'h2, rv);
      xfer(1'h1, 32'h30, 32'h2);
      xfer(1'h0, 32'h30, 32'h0);
      chk("flag cleared", 32'h0, rv);
      $display("interrupt test done");
      print_verdict();
   end
endmodule // pt8_timer_tb
